/* File: design/spm_defs.svh */
// constants for the sprite pair colour merge block
//
// Functional notes
// - only odd sprite pairs with even below
// - attach flag is odd control bit 7
// - all four pairs may attach together
// - attached pair gives 4-bit colour selector
// - odd gives upper bits, high word leads
// - both data words of a sprite shift together
// - attached selector n picks register 16+n
// - attached selector zero is transparent
// - lone even sprite uses registers 17-19
// - lone odd sprite uses 20, 24, 28
// - direct writes accepted when DMA not owning
// - second data first; first data arms
// - armed sprite repeats data every line
// - control write disarms the sprite
// - position write moves sprite any time
// - shift 16 bits MSB first, then stop
// - start only when comparator armed, match
`ifndef SPM_DEFS_SVH
`define SPM_DEFS_SVH

// ----------------------------------------------------------------
// register map, byte addresses
// ----------------------------------------------------------------
`define SPM_SPR_AREA_BIT 7
`define SPM_OFF_STATUS 8'h80
`define SPM_OFF_HCOUNT 8'h84

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define SPM_CTL_ATTACH_BIT 7
`define SPM_CTL_H0_BIT 0
`define SPM_REG_RESET 16'h0000
`define SPM_SHIFT_LEN 5'h10
`define SPM_ATT_COLOR_BASE 5'h10
`define SPM_PAIR_STEP 5'h04

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SPM_PIX_DIV 2
`define SPM_LINE_LEN 9'h1C7

`endif

/* File: design/spm_pkg.sv */
// shared types of the sprite pair colour merge block
package spm_pkg;
  // register selector within one sprite
  typedef enum logic [1:0] {
    SPM_REG_POS  = 2'h0,
    SPM_REG_CTL  = 2'h1,
    SPM_REG_DATA = 2'h2,
    SPM_REG_DATB = 2'h3
  } spm_reg_t;
  typedef logic [1:0] spm_pix_t;   // one sprite's 2-bit pixel
  typedef logic [8:0] spm_hpos_t;  // horizontal position
endpackage : spm_pkg

/* File: design/spm_sprite_if.sv */
// per-sprite link between the register file and one channel
`timescale 1ns/1ps
`default_nettype none
interface spm_sprite_if;
  logic tick;                  // low-resolution pixel enable
  spm_pkg::spm_hpos_t hcount;  // beam position
  spm_pkg::spm_hpos_t horizontal_start_pos;  // programmed start position
  logic wr_ctl;                // control register written
  logic wr_arm;                // first data register written
  logic [15:0] data_a;         // low-order word
  logic [15:0] data_b;         // high-order word
  spm_pkg::spm_pix_t pix;      // serial pixel out
  logic armed;                 // comparator enabled
  modport chan (input tick, hcount, horizontal_start_pos, wr_ctl, wr_arm, data_a,
    data_b, output pix, armed);
  modport ctrl (output tick, hcount, horizontal_start_pos, wr_ctl, wr_arm, data_a,
    data_b, input pix, armed);
endinterface : spm_sprite_if
`default_nettype wire

/* File: design/spm_sprite_chan.sv */
// one sprite: arming comparator and parallel-to-serial shifters
`timescale 1ns/1ps
`default_nettype none
`include "spm_defs.svh"
module spm_sprite_chan (
  input wire logic clock,
  input wire logic reset,
  spm_sprite_if.chan sif
);
  logic armed_q, armed_d;   // horizontal comparator enable
  logic [15:0] sa_q, sa_d;  // low-order shifter
  logic [15:0] sb_q, sb_d;  // high-order shifter
  logic [4:0] cnt_q, cnt_d; // bits still to shift

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    armed_d = armed_q;
    sa_d = sa_q;
    sb_d = sb_q;
    cnt_d = cnt_q;
    if (sif.wr_ctl) begin
      armed_d = 1'b0;
    end else if (sif.wr_arm) begin
      armed_d = 1'b1;
    end
    if (sif.wr_ctl) begin
      cnt_d = 5'h00;  // a disarm also cuts a line in flight
    end else if (sif.tick) begin
      if (cnt_q != 5'h00) begin
        // msb leaves first, both words in step
        sa_d = {sa_q[14:0], 1'b0};
        sb_d = {sb_q[14:0], 1'b0};
        cnt_d = cnt_q - 5'h01;
      end else if (armed_q && (sif.hcount == sif.horizontal_start_pos)) begin
        // held words reload each line while armed
        sa_d = sif.data_a;
        sb_d = sif.data_b;
        cnt_d = `SPM_SHIFT_LEN;
      end
    end
  end

  // registers only
  always_ff @(posedge clock) begin
    if (reset) begin
      armed_q <= 1'b0;
      sa_q <= `SPM_REG_RESET;
      sb_q <= `SPM_REG_RESET;
      cnt_q <= 5'h00;
    end else begin
      armed_q <= armed_d;
      sa_q <= sa_d;
      sb_q <= sb_d;
      cnt_q <= cnt_d;
    end
  end

  // high word is the more significant bit
  assign sif.pix = (cnt_q != 5'h00) ? {sb_q[15], sa_q[15]} : 2'h0;
  assign sif.armed = armed_q;
endmodule : spm_sprite_chan
`default_nettype wire

/* File: design/spm_pair_merge.sv */
// colour register choice for one even/odd sprite pair
`timescale 1ns/1ps
`default_nettype none
`include "spm_defs.svh"
module spm_pair_merge #(
  parameter logic [4:0] PAIR_BASE = 5'h10
) (
  input wire spm_pkg::spm_pix_t even_pix,
  input wire spm_pkg::spm_pix_t odd_pix,
  input wire logic attach,
  output logic [4:0] color,
  output logic visible
);
  logic [3:0] sel;  // combined 4-bit selector

  // ----------------------------------------------------------------
  // merge
  // ----------------------------------------------------------------
  always_comb begin
    sel = {odd_pix, even_pix};  // odd above even
    color = 5'h00;
    if (attach) begin
      // a lone sprite of a misaligned pair lands on 17-19 or
      // 20/24/28 by the same sum
      if (sel != 4'h0) begin
        color = `SPM_ATT_COLOR_BASE + {1'b0, sel};
      end
      // zero stays transparent, never register 16
    end else if (even_pix != 2'h0) begin
      // lower number wins inside an unattached pair
      color = PAIR_BASE + {3'h0, even_pix};
    end else if (odd_pix != 2'h0) begin
      color = PAIR_BASE + {3'h0, odd_pix};
    end
    visible = (color != 5'h00);
  end
endmodule : spm_pair_merge
`default_nettype wire

/* File: design/spm_top.sv */
// sprite pixel path: registers, eight channels, four pair mergers
`timescale 1ns/1ps
`default_nettype none
`include "spm_defs.svh"
module spm_top #(
  parameter int PIX_DIV = `SPM_PIX_DIV,
  parameter logic [8:0] LINE_LEN = `SPM_LINE_LEN
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic dma_wr_valid,
  input wire logic [2:0] dma_wr_sprite,
  input wire spm_pkg::spm_reg_t dma_wr_reg,
  input wire logic [15:0] dma_wr_data,
  input wire logic [7:0] dma_owns,
  output logic [19:0] pair_color,
  output logic [3:0] pair_visible,
  output logic [3:0] pair_attached
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] div_q, div_d;            // pixel enable divider
  logic tick_q, tick_d;                // one lores pixel time
  logic [8:0] hcount_q, hcount_d;      // horizontal beam counter
  logic pready_q, pready_d;            // apb answer
  logic pslverr_q, pslverr_d;          // apb error answer
  logic [31:0] prdata_q, prdata_d;     // apb read data
  logic access;                        // apb access phase
  logic commit;                        // edge where a transfer ends
  logic spr_area;                      // address hits sprite words
  logic [2:0] spr_idx;                 // addressed sprite
  spm_pkg::spm_reg_t spr_reg;          // addressed register
  logic mapped;                        // address has a register
  logic apb_wr;                        // accepted direct write
  logic [7:0][15:0] pos_all;           // position words
  logic [7:0][15:0] ctl_all;           // control words
  logic [7:0][15:0] data_a_all;        // first data words
  logic [7:0][15:0] data_b_all;        // second data words
  logic [7:0][1:0] pix_all;            // serial pixels
  logic [7:0] armed_all;               // comparator enables
  logic [3:0] attach_all;              // attach flags per pair

  spm_sprite_if sif[8] ();

  // ----------------------------------------------------------------
  // pixel enable and beam counter
  // ----------------------------------------------------------------
  // one clock only: the lores pixel rate is an enable pulse
  always_comb begin
    div_d = div_q + 8'h01;
    tick_d = 1'b0;
    hcount_d = hcount_q;
    if (div_q == 8'(PIX_DIV - 1)) begin
      div_d = 8'h00;
      tick_d = 1'b1;
    end
    if (tick_q) begin
      // wrap at the end of a line
      if (hcount_q == (LINE_LEN - 9'h001)) begin
        hcount_d = 9'h000;
      end else begin
        hcount_d = hcount_q + 9'h001;
      end
    end
  end

  // registers only
  always_ff @(posedge clock) begin
    if (reset) begin
      div_q <= 8'h00;
      tick_q <= 1'b0;
      hcount_q <= 9'h000;
    end else begin
      div_q <= div_d;
      tick_q <= tick_d;
      hcount_q <= hcount_d;
    end
  end

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  always_comb begin
    access = psel && penable;
    commit = access && pready_q;
    spr_area = !paddr[`SPM_SPR_AREA_BIT];
    spr_idx = paddr[6:4];
    spr_reg = spm_pkg::spm_reg_t'(paddr[3:2]);
    mapped = spr_area || (paddr == `SPM_OFF_STATUS) ||
      (paddr == `SPM_OFF_HCOUNT);
    // a channel owned by dma ignores direct writes
    apb_wr = commit && pwrite && spr_area && !dma_owns[spr_idx];
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // one wait cycle; read data is captured on the first access edge
  // and holds through the cycle where pready is high
  always_comb begin
    pready_d = access && !pready_q;
    pslverr_d = access && !pready_q && !mapped;
    prdata_d = prdata_q;
    if (access && !pready_q) begin
      prdata_d = 32'h0000_0000;
      if (spr_area) begin
        case (spr_reg)
          spm_pkg::SPM_REG_POS: begin
            prdata_d[15:0] = pos_all[spr_idx];
          end
          spm_pkg::SPM_REG_CTL: begin
            prdata_d[15:0] = ctl_all[spr_idx];
          end
          spm_pkg::SPM_REG_DATA: begin
            prdata_d[15:0] = data_a_all[spr_idx];
          end
          default: begin
            prdata_d[15:0] = data_b_all[spr_idx];
          end
        endcase
      end else if (paddr == `SPM_OFF_STATUS) begin
        // live state of the block
        prdata_d[11:0] = {attach_all, armed_all};
      end else if (paddr == `SPM_OFF_HCOUNT) begin
        prdata_d[8:0] = hcount_q;
      end
    end
  end

  // registers only
  always_ff @(posedge clock) begin
    if (reset) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ----------------------------------------------------------------
  // per-sprite registers and channels
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 8; g++) begin : gen_spr
    logic [15:0] pos_q, pos_d;      // position word
    logic [15:0] ctl_q, ctl_d;      // control word
    logic [15:0] data_a_q, data_a_d; // first data word
    logic [15:0] data_b_q, data_b_d; // second data word
    logic dma_hit;                  // dma addresses this sprite
    logic apb_hit;                  // direct write to this sprite
    logic [15:0] wdata;             // winning write data
    logic [3:0] wr;                 // per-register write strobes

    // strobes: dma wins if both name the same sprite
    always_comb begin
      dma_hit = dma_wr_valid && (dma_wr_sprite == 3'(g));
      apb_hit = apb_wr && (spr_idx == 3'(g));
      wdata = dma_hit ? dma_wr_data : pwdata[15:0];
      wr = 4'h0;
      if (dma_hit) begin
        wr[dma_wr_reg] = 1'b1;
      end else if (apb_hit) begin
        wr[spr_reg] = 1'b1;
      end
    end

    // next register values
    always_comb begin
      pos_d = pos_q;
      ctl_d = ctl_q;
      data_a_d = data_a_q;
      data_b_d = data_b_q;
      if (wr[spm_pkg::SPM_REG_POS]) begin
        pos_d = wdata;  // takes effect at once
      end
      if (wr[spm_pkg::SPM_REG_CTL]) begin
        ctl_d = wdata;
      end
      if (wr[spm_pkg::SPM_REG_DATA]) begin
        data_a_d = wdata;
      end
      if (wr[spm_pkg::SPM_REG_DATB]) begin
        data_b_d = wdata;
      end
    end

    // registers only
    always_ff @(posedge clock) begin
      if (reset) begin
        pos_q <= `SPM_REG_RESET;
        ctl_q <= `SPM_REG_RESET;
        data_a_q <= `SPM_REG_RESET;
        data_b_q <= `SPM_REG_RESET;
      end else begin
        pos_q <= pos_d;
        ctl_q <= ctl_d;
        data_a_q <= data_a_d;
        data_b_q <= data_b_d;
      end
    end

    // channel hookup; a position write moves the comparator target
    // on the very next pixel, even mid-frame
    assign sif[g].tick = tick_q;
    assign sif[g].hcount = hcount_q;
    assign sif[g].horizontal_start_pos = {pos_q[7:0], ctl_q[`SPM_CTL_H0_BIT]};
    assign sif[g].wr_ctl = wr[spm_pkg::SPM_REG_CTL];
    assign sif[g].wr_arm = wr[spm_pkg::SPM_REG_DATA];
    // the shifter takes the stored second word, so it must be
    // written before the first one arms the sprite
    assign sif[g].data_a = data_a_q;
    assign sif[g].data_b = data_b_q;

    assign pos_all[g] = pos_q;
    assign ctl_all[g] = ctl_q;
    assign data_a_all[g] = data_a_q;
    assign data_b_all[g] = data_b_q;
    assign pix_all[g] = sif[g].pix;
    assign armed_all[g] = sif[g].armed;

    spm_sprite_chan u_chan (
      .clock (clock),
      .reset (reset),
      .sif (sif[g])
    );
  end

  // ----------------------------------------------------------------
  // pair merge and output registers
  // ----------------------------------------------------------------
  // pairs are fixed as odd over the even one below, each
  // pair has its own flag so any mix may attach
  for (genvar k = 0; k < 4; k++) begin : gen_pair
    localparam logic [4:0] BASE = `SPM_ATT_COLOR_BASE +
      5'(k * 4);
    logic [4:0] color;              // merged colour register
    logic visible;                  // not transparent
    logic [4:0] color_q, color_d;   // registered colour
    logic vis_q, vis_d;             // registered visibility
    logic att_q, att_d;             // registered attach state

    // only the odd sprite's control bit 7 attaches
    assign attach_all[k] = ctl_all[2*k+1][`SPM_CTL_ATTACH_BIT];

    spm_pair_merge #(
      .PAIR_BASE (BASE)
    ) u_merge (
      .even_pix (pix_all[2*k]),
      .odd_pix (pix_all[2*k+1]),
      .attach (attach_all[k]),
      .color (color),
      .visible (visible)
    );

    // only the merged result and the attach flag leave the pair
    always_comb begin
      color_d = color;
      vis_d = visible;
      att_d = attach_all[k];
    end

    // registers only
    always_ff @(posedge clock) begin
      if (reset) begin
        color_q <= 5'h00;
        vis_q <= 1'b0;
        att_q <= 1'b0;
      end else begin
        color_q <= color_d;
        vis_q <= vis_d;
        att_q <= att_d;
      end
    end

    assign pair_color[k*5 +: 5] = color_q;
    assign pair_visible[k] = vis_q;
    assign pair_attached[k] = att_q;
  end

endmodule : spm_top
`default_nettype wire

/* File: verif/spm_top_sva.sv */
// checker for the sprite pair colour merge top level
`timescale 1ns/1ps
`default_nettype none
module spm_top_sva #(
  parameter int PIX_DIV = 2,
  parameter logic [8:0] LINE_LEN = 9'h1C7
) (
  input wire logic clock,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [7:0] dma_owns,
  input wire logic [19:0] pair_color,
  input wire logic [3:0] pair_visible,
  input wire logic [3:0] pair_attached
);
  // one clock domain, so one default for all checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);
  // ----------------------------------------------------------------
  // bus steps
  // ----------------------------------------------------------------
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_commit;
    psel && penable && pready;
  endsequence
  pulse_once_a: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  ready_access_a: assert property (pready |-> psel && penable)
    else $error("pready outside an access phase");
  setup_quiet_a: assert property (s_setup |-> !pready)
    else $error("pready during setup");
  wait_state_a: assert property (s_setup |=> !pready ##1 s_commit)
    else $error("answer not after exactly one wait state");
  // only the sprite area and the two status words are mapped
  err_decode_a: assert property (pready |-> pslverr == !((paddr < 8'h80) ||
    (paddr == 8'h80) || (paddr == 8'h84)))
    else $error("pslverr does not follow the address map");
  err_zero_a: assert property (pready && !pwrite && pslverr |->
    prdata == 32'h0)
    else $error("refused read returned data");
  upper_zero_a: assert property (pready && !pwrite && paddr < 8'h80 |->
    prdata[31:16] == 16'h0)
    else $error("upper read bits not zero");
  // ----------------------------------------------------------------
  // colour path
  // ----------------------------------------------------------------
  visible_sel_a: assert property (pair_visible == {pair_color[19],
    pair_color[14], pair_color[9], pair_color[4]})
    else $error("visible flag and colour disagree");
  // settled detach, so no merged pixel may still be in flight
  lone_pair_a: assert property (pair_visible[0] && !pair_attached[0] &&
    !$past(pair_attached[0], 3) |->
    pair_color[1:0] == 2'h0 || pair_color[3:2] == 2'h0)
    else $error("lone sprite colour outside its set");
  attach_follow_a: assert property (s_commit ##0 pwrite &&
    paddr == 8'h14 && !dma_owns[1] |->
    ##2 pair_attached[0] == $past(pwdata[7], 2))
    else $error("attach flag does not follow control bit");
endmodule : spm_top_sva
bind spm_top spm_top_sva #(.PIX_DIV(PIX_DIV), .LINE_LEN(LINE_LEN))
  spm_top_sva_inst (.*);
`default_nettype wire

/* File: verif/spm_dma_model.sv */
// model of the sprite fetch channel writing sprite registers
`timescale 1ns/1ps
`default_nettype none
module spm_dma_model (
  input wire logic clock,
  output logic dma_wr_valid,
  output logic [2:0] dma_wr_sprite,
  output var spm_pkg::spm_reg_t dma_wr_reg,
  output logic [15:0] dma_wr_data,
  output logic [7:0] dma_owns
);
  // idle channel at time zero
  initial begin
    dma_wr_valid = 1'b0;
    dma_wr_sprite = 3'h0;
    dma_wr_reg = spm_pkg::SPM_REG_POS;
    dma_wr_data = 16'h0000;
    dma_owns = 8'h00;
  end
  // one-cycle write pulse; released lines do not keep the last word
  task automatic wr(input logic [2:0] s, input spm_pkg::spm_reg_t r,
    input logic [15:0] d);
    @(posedge clock);
    dma_wr_valid <= 1'b1;
    dma_wr_sprite <= s;
    dma_wr_reg <= r;
    dma_wr_data <= d;
    @(posedge clock);
    dma_wr_valid <= 1'b0;
    dma_wr_sprite <= ~s;
    dma_wr_data <= ~d;
  endtask : wr
  // channel claims sprites, locking out direct writes
  task automatic own(input logic [7:0] m);
    @(posedge clock);
    dma_owns <= m;
  endtask : own
  // one line of data, second word first since the first one arms
  task automatic load(input logic [2:0] s, input logic [15:0] a,
    input logic [15:0] b);
    wr(s, spm_pkg::SPM_REG_DATB, b);
    wr(s, spm_pkg::SPM_REG_DATA, a);
  endtask : load
  // both sprites of a pair get one position, then control words
  task automatic place(input logic [1:0] k, input logic [7:0] p,
    input logic att);
    wr({k, 1'b0}, spm_pkg::SPM_REG_POS, {8'h00, p});
    wr({k, 1'b1}, spm_pkg::SPM_REG_POS, {8'h00, p});
    wr({k, 1'b0}, spm_pkg::SPM_REG_CTL, 16'h0000);
    wr({k, 1'b1}, spm_pkg::SPM_REG_CTL, {8'h00, att, 7'h00});
  endtask : place
endmodule : spm_dma_model
`default_nettype wire

/* File: verif/testbench.sv */
// self-checking bench for the sprite pair colour merge block
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clock, reset, psel, penable, pwrite, pready, pslverr, er;
  logic [7:0] paddr, dma_owns;
  logic [31:0] pwdata, prdata, rd;
  logic dma_wr_valid;
  logic [2:0] dma_wr_sprite;
  spm_pkg::spm_reg_t dma_wr_reg;
  logic [15:0] dma_wr_data;
  logic [19:0] pair_color;
  logic [3:0] pair_visible, pair_attached;
  int n_mismatch = 0, total_checks = 0, cyc = 0, fc0 = 0, fc = 0;
  // even first/second words, odd first/second words
  localparam logic [15:0] EA = 16'hF0F0, EB = 16'hCCCC;
  localparam logic [15:0] OA = 16'hAAAA, OB = 16'h0FF0;
  // short line and one clock per pixel keep the run brief
  spm_top #(.PIX_DIV(1), .LINE_LEN(9'h020)) spm_top_inst (.clock(clock),
    .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .dma_wr_valid(dma_wr_valid),
    .dma_wr_sprite(dma_wr_sprite), .dma_wr_reg(dma_wr_reg),
    .dma_wr_data(dma_wr_data), .dma_owns(dma_owns),
    .pair_color(pair_color), .pair_visible(pair_visible),
    .pair_attached(pair_attached));
  spm_dma_model spm_dma_model_inst (.clock(clock),
    .dma_wr_valid(dma_wr_valid), .dma_wr_sprite(dma_wr_sprite),
    .dma_wr_reg(dma_wr_reg), .dma_wr_data(dma_wr_data),
    .dma_owns(dma_owns));
  // ----------------------------------------------------------------
  // clock, cycle count, watchdog
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) cyc <= cyc + 1;
  initial begin
    repeat (20000) @(posedge clock);
    n_mismatch++;
    finish_test();
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string what, input logic [31:0] exp,
    input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // one bus transfer, held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int i;
    i = 0;
    @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      n_mismatch++;
      finish_test();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp,
    input string what);
    apb(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rchk
  // pair 0 output: start after an idle gap, then 16 pixels
  task automatic grab(input logic att, input logic [15:0] ea, eb, oa, ob);
    int i, z;
    logic [4:0] e;
    logic [1:0] pe, po;
    i = 0;
    z = 0;
    while (i < 200 && !(z >= 3 && pair_color[4:0] !== 5'h00)) begin
      z = (pair_color[4:0] === 5'h00) ? z + 1 : 0;
      @(posedge clock);
      i++;
    end
    if (i >= 200) begin
      n_mismatch++;
      finish_test();
    end
    fc0 = fc;
    fc = cyc;
    for (int j = 15; j >= 0; j--) begin
      pe = {eb[j], ea[j]};
      po = {ob[j], oa[j]};
      if (att) e = ({po, pe} == 4'h0) ? 5'h00 : {1'b1, po, pe};
      else e = (pe != 2'h0) ? {3'h4, pe} :
        ((po != 2'h0) ? {3'h4, po} : 5'h00);
      chk("pair_color", {27'h0, e}, {27'h0, pair_color[4:0]});
      @(posedge clock);
    end
  endtask : grab
  // ----------------------------------------------------------------
  // sequence of tests
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    rchk(8'h80, 32'h0, "status reset");
    rchk(8'h88, 32'h0, "unmapped read");
    chk("pslverr", 32'h1, {31'h0, er});
    apb(1'b1, 8'h30, 32'hFFFF1234);
    rchk(8'h30, 32'h1234, "pos3");
    $display("test registers done");
    spm_dma_model_inst.own(8'h04);
    apb(1'b1, 8'h20, 32'h005A);
    rchk(8'h20, 32'h0, "pos2 owned");
    spm_dma_model_inst.wr(3'h2, spm_pkg::SPM_REG_POS, 16'h0077);
    rchk(8'h20, 32'h77, "pos2 dma");
    spm_dma_model_inst.own(8'h00);
    apb(1'b1, 8'h20, 32'h0);
    rchk(8'h20, 32'h0, "pos2 free");
    $display("test ownership done");
    spm_dma_model_inst.place(2'h0, 8'h02, 1'b1);
    spm_dma_model_inst.load(3'h0, EA, EB);
    spm_dma_model_inst.load(3'h1, OA, OB);
    rchk(8'h80, 32'h0103, "status attached");
    grab(1'b1, EA, EB, OA, OB);
    grab(1'b1, EA, EB, OA, OB);
    chk("line period", 32'h0, (fc - fc0) % 32);
    $display("test attached done");
    for (int k = 1; k < 4; k++) apb(1'b1, 8'(8'h14 + 8'h20 * k), 32'h80);
    rchk(8'h80, 32'h0F03, "status all");
    chk("attached", 32'hF, {28'h0, pair_attached});
    $display("test all pairs done");
    apb(1'b1, 8'h00, 32'h05);
    apb(1'b1, 8'h10, 32'h05);
    // let any line drawn between the two moves pass first
    repeat (32) @(posedge clock);
    grab(1'b1, EA, EB, OA, OB);
    chk("moved start", 32'h6, (fc - fc0) % 32);
    $display("test move done");
    apb(1'b1, 8'h14, 32'h0);
    rchk(8'h80, 32'h0E01, "status detached");
    grab(1'b0, EA, EB, 16'h0, 16'h0);
    $display("test detach done");
    // odd sprite of an attached pair shown without its even partner
    apb(1'b1, 8'h04, 32'h0);
    apb(1'b1, 8'h14, 32'h80);
    apb(1'b1, 8'h1C, {16'h0, OB});
    apb(1'b1, 8'h18, {16'h0, OA});
    rchk(8'h80, 32'h0F02, "status odd");
    grab(1'b1, 16'h0, 16'h0, OA, OB);
    $display("test odd alone done");
    finish_test();
  end
endmodule : testbench
`default_nettype wire
